//--- design/plk_defs.svh
`ifndef PLK_DEFS_SVH
`define PLK_DEFS_SVH

// ----------------------------------------------------------------
// Register selects on the host port
// ----------------------------------------------------------------
`define PLK_SEL_WR_ADDR   3'h0
`define PLK_SEL_COLOR     3'h1
`define PLK_SEL_MASK      3'h2
`define PLK_SEL_RD_ADDR   3'h3
`define PLK_SEL_COMMAND   3'h4
`define PLK_SEL_PLL_INDEX 3'h5
`define PLK_SEL_PLL_DATA  3'h6
`define PLK_SEL_PLL_CTRL  3'h7

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PLK_CMD_MODE_HI   7
`define PLK_CMD_MODE_LO   5
`define PLK_CMD_DAC8_BIT  1
`define PLK_CMD_RESET     8'h00
`define PLK_MASK_RESET    8'hff
`define PLK_PLL_CTRL_RESET 3'h0
`define PLK_PLL_COUNT     9
`define PLK_PLL_MEM_INDEX 4'h8
`define PLK_PLL_FIXED_TOP 4'h1
`define PLK_PLL_DEFAULT_BASE 8'h10 // Arbitrary first default clock word
`define PLK_PALETTE_DEPTH 256
`define PLK_COLOR_BYTES   2'h3

// ----------------------------------------------------------------
// Timing in nanoseconds and pixel clock cycles
// ----------------------------------------------------------------
`define PLK_CLK_PERIOD_NS 20
`define PLK_STROBE_NS     50
`define PLK_SETUP_NS      10
`define PLK_STROBE_CYC ((`PLK_STROBE_NS + `PLK_CLK_PERIOD_NS - 1) / `PLK_CLK_PERIOD_NS)
`define PLK_SETUP_CYC  ((`PLK_SETUP_NS + `PLK_CLK_PERIOD_NS - 1) / `PLK_CLK_PERIOD_NS)
`define PLK_GAP_SHORT     4
`define PLK_GAP_LONG      8

`endif

//--- design/plk_pkg.sv
package plk_pkg;

    // Palette entry: three 6-bit colour fields, red highest
    typedef logic [17:0] plk_color_type;
    typedef logic [7:0]  plk_byte_type;
    typedef logic [2:0]  plk_sel_type;

    // Host sequencer states
    typedef enum logic [1:0] {
        PLK_IDLE,
        PLK_SETUP,
        PLK_STROBE,
        PLK_GAP
    } plk_host_state_type;

endpackage : plk_pkg

//--- design/plk_link_if.sv
`timescale 1ns/1ns
interface plk_link_if;
    import plk_pkg::*;

    plk_byte_type pix_addr;      // Pixel address, valid every edge
    logic         blank_n;       // Active-low blanking
    logic         wr_n;          // Write strobe
    logic         rd_n;          // Read strobe
    plk_sel_type  sel;           // Register select
    plk_byte_type data_host;     // Host drive of data bus
    logic         data_host_oe;
    plk_byte_type data_dev;      // Device drive of data bus
    logic         data_dev_oe;
    plk_byte_type data_bus;      // Resolved bus level

    // Resolve the shared data bus from the two enables
    assign data_bus = data_dev_oe ? data_dev : (data_host_oe ? data_host : 8'hff);

    modport dev (
        input  pix_addr, blank_n, wr_n, rd_n, sel, data_bus,
        output data_dev, data_dev_oe
    );
    modport host (
        output pix_addr, blank_n, wr_n, rd_n, sel, data_host, data_host_oe,
        input  data_bus
    );

endinterface : plk_link_if

//--- design/plk_device.sv
// Operation
// - Palette of 256 entries, 18 bits each
// - Three colour channels, 6/8-bit selectable
// - Blanking acts on all three channels
// - Blanking delayed same depth as pixels
// - Pixel address masked before palette lookup
// - Mask writable anytime, no pixel alignment
// - Host waits 4 cycles after write
// - Host waits 4 cycles after read
// - Host waits 4 cycles after colour write
// - Host waits 8 cycles after colour read
// - Host waits 8 cycles after read address
// - Pixel address valid at every edge
// - Eight video clocks, six programmable, one memory
// - Clock frequency registers load defaults at reset
// - Sampled pixel reaches outputs three edges later
// - Resets to 6-bit palette mode, mode bits 7:5
// - Converters powered down while blanking low
`timescale 1ns/1ns
`include "plk_defs.svh"

module plk_device (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    plk_link_if.dev                link,
    output logic [7:0]             o_red,
    output logic [7:0]             o_green,
    output logic [7:0]             o_blue,
    output logic                   o_dac_on,
    output logic                   o_dac_wide,
    output logic [2:0]             o_video_mode,
    output logic [2:0]             o_video_clock_index,
    output plk_pkg::plk_byte_type  o_video_clock_out_word,
    output plk_pkg::plk_byte_type  o_memory_clock_out_word
);
    import plk_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // palette array
    plk_color_type palette [0:`PLK_PALETTE_DEPTH-1];
    plk_byte_type  pll_word [0:`PLK_PLL_COUNT-1];
    plk_byte_type  mask;
    plk_byte_type  command;
    plk_byte_type  wr_addr;
    plk_byte_type  rd_addr;
    logic [3:0]    pll_index;
    logic [2:0]    pll_ctrl;
    logic [1:0]    wr_phase;
    logic [1:0]    rd_phase;
    logic [11:0]   wr_hold;
    plk_color_type rd_buf;
    logic          rd_fetch;
    logic          wr_n_q;
    logic          rd_n_q;
    plk_byte_type  wr_data_q;
    plk_sel_type   wr_sel_q;
    plk_byte_type  rd_out;

    // Pixel pipeline
    plk_byte_type  pipe_addr;
    logic          pipe_blank1;
    plk_color_type pipe_color;
    logic          pipe_blank2;
    plk_color_type pipe_color3;
    logic          pipe_blank3;

    // ----------------------------------------------------------------
    // Strobe decode
    // ----------------------------------------------------------------
    // strobes sampled on pixel clock
    wire wr_end    = !wr_n_q && link.wr_n;
    wire rd_start  = rd_n_q && !link.rd_n;
    wire rd_end    = !rd_n_q && link.rd_n;
    wire wr_color  = wr_end && (wr_sel_q == `PLK_SEL_COLOR);
    wire wr_commit = wr_color && (wr_phase == 2'h2);
    wire rd_color  = rd_end && (link.sel == `PLK_SEL_COLOR);
    wire rd_last   = rd_color && (rd_phase == 2'h2);
    wire pll_fixed = pll_index <= `PLK_PLL_FIXED_TOP;

    wire plk_byte_type masked_addr = link.pix_addr & mask;

    // Colour byte chosen by the read phase
    wire [5:0] rd_field = (rd_phase == 2'h0) ? rd_buf[17:12] :
                          (rd_phase == 2'h1) ? rd_buf[11:6] : rd_buf[5:0];

    // Register read mux
    wire plk_byte_type rd_mux =
        (link.sel == `PLK_SEL_WR_ADDR)   ? wr_addr :
        (link.sel == `PLK_SEL_COLOR)     ? {2'h0, rd_field} :
        (link.sel == `PLK_SEL_MASK)      ? mask :
        (link.sel == `PLK_SEL_RD_ADDR)   ? rd_addr :
        (link.sel == `PLK_SEL_COMMAND)   ? command :
        (link.sel == `PLK_SEL_PLL_INDEX) ? {4'h0, pll_index} :
        (link.sel == `PLK_SEL_PLL_DATA)  ? pll_word[pll_index] :
                                           {5'h00, pll_ctrl};

    // ----------------------------------------------------------------
    // Host port capture
    // ----------------------------------------------------------------
    // Latch write data while strobe low, read data at strobe start
    always_ff @(posedge i_clk_sys) begin
        wr_n_q <= i_rst ? 1'b1 : link.wr_n;
        rd_n_q <= i_rst ? 1'b1 : link.rd_n;
        if (!link.wr_n) begin
            wr_data_q <= link.data_bus;
            wr_sel_q  <= link.sel;
        end
        if (rd_start) begin
            rd_out <= rd_mux;
        end
    end

    // Bus driven from the second strobe cycle until strobe ends
    assign link.data_dev    = rd_out;
    assign link.data_dev_oe = !rd_n_q && !link.rd_n;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // mask taken on any write end with the mask select
    // command resets to 6-bit palette mode
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            mask      <= `PLK_MASK_RESET;
            command   <= `PLK_CMD_RESET;
            pll_index <= 4'h0;
            pll_ctrl  <= `PLK_PLL_CTRL_RESET;
        end else if (wr_end) begin
            if (wr_sel_q == `PLK_SEL_MASK) begin
                mask <= wr_data_q;
            end else if (wr_sel_q == `PLK_SEL_COMMAND) begin
                command <= wr_data_q;
            end else if (wr_sel_q == `PLK_SEL_PLL_INDEX) begin
                pll_index <= wr_data_q[3:0];
            end else if (wr_sel_q == `PLK_SEL_PLL_CTRL) begin
                pll_ctrl <= wr_data_q[2:0];
            end
        end
    end

    // six video words and memory word programmable
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int i = 0; i < `PLK_PLL_COUNT; i++) begin
                pll_word[i] <= `PLK_PLL_DEFAULT_BASE + 8'(i);
            end
        end else if (wr_end && wr_sel_q == `PLK_SEL_PLL_DATA && !pll_fixed
                     && pll_index <= `PLK_PLL_MEM_INDEX) begin
            pll_word[pll_index] <= wr_data_q;
        end
    end

    // ----------------------------------------------------------------
    // Palette host access
    // ----------------------------------------------------------------
    // colour write commits after third byte
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            wr_addr  <= 8'h00;
            wr_phase <= 2'h0;
            wr_hold  <= 12'h000;
        end else if (wr_end && wr_sel_q == `PLK_SEL_WR_ADDR) begin
            wr_addr  <= wr_data_q;
            wr_phase <= 2'h0;
        end else if (wr_color) begin
            wr_hold  <= {wr_hold[5:0], wr_data_q[5:0]};
            wr_phase <= wr_commit ? 2'h0 : wr_phase + 2'h1;
            if (wr_commit) begin
                wr_addr <= wr_addr + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (wr_commit) begin
            palette[wr_addr] <= {wr_hold, wr_data_q[5:0]};
        end
    end

    // fetch one cycle after read address write
    // refetch next entry after third byte
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rd_addr  <= 8'h00;
            rd_phase <= 2'h0;
            rd_fetch <= 1'b0;
            rd_buf   <= 18'h00000;
        end else begin
            rd_fetch <= 1'b0;
            if (rd_fetch) begin
                rd_buf <= palette[rd_addr];
            end
            if (wr_end && wr_sel_q == `PLK_SEL_RD_ADDR) begin
                rd_addr  <= wr_data_q;
                rd_phase <= 2'h0;
                rd_fetch <= 1'b1;
            end else if (rd_color) begin
                rd_phase <= rd_last ? 2'h0 : rd_phase + 2'h1;
                if (rd_last) begin
                    rd_addr  <= rd_addr + 8'h01;
                    rd_fetch <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Pixel pipeline
    // ----------------------------------------------------------------
    // address sampled every edge
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pipe_addr   <= 8'h00;
            pipe_blank1 <= 1'b0;
            pipe_blank2 <= 1'b0;
            pipe_blank3 <= 1'b0;
            pipe_color  <= 18'h00000;
            pipe_color3 <= 18'h00000;
        end else begin
            pipe_addr   <= masked_addr;
            pipe_blank1 <= link.blank_n;
            pipe_color  <= palette[pipe_addr];
            pipe_blank2 <= pipe_blank1;
            pipe_color3 <= pipe_color;
            pipe_blank3 <= pipe_blank2;
        end
    end

    // Colour formatting for 6 or 8 bit converters
    wire       dac_wide = command[`PLK_CMD_DAC8_BIT];
    wire [7:0] red_fmt  = dac_wide ? {pipe_color3[17:12], 2'h0} : {2'h0, pipe_color3[17:12]};
    wire [7:0] grn_fmt  = dac_wide ? {pipe_color3[11:6], 2'h0} : {2'h0, pipe_color3[11:6]};
    wire [7:0] blu_fmt  = dac_wide ? {pipe_color3[5:0], 2'h0} : {2'h0, pipe_color3[5:0]};

    // outputs update on third edge after sampling
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_red      <= 8'h00;
            o_green    <= 8'h00;
            o_blue     <= 8'h00;
            o_dac_on   <= 1'b0;
            o_dac_wide <= 1'b0;
            o_video_mode            <= 3'h0;
            o_video_clock_index     <= 3'h0;
            o_video_clock_out_word  <= 8'h00;
            o_memory_clock_out_word <= 8'h00;
        end else begin
            o_red      <= pipe_blank3 ? red_fmt : 8'h00;
            o_green    <= pipe_blank3 ? grn_fmt : 8'h00;
            o_blue     <= pipe_blank3 ? blu_fmt : 8'h00;
            o_dac_on   <= pipe_blank3;
            o_dac_wide <= dac_wide;
            // Mode and clock selection outputs
            o_video_mode            <= command[`PLK_CMD_MODE_HI:`PLK_CMD_MODE_LO];
            o_video_clock_index     <= pll_ctrl;
            o_video_clock_out_word  <= pll_word[pll_ctrl];
            o_memory_clock_out_word <= pll_word[`PLK_PLL_MEM_INDEX];
        end
    end

endmodule : plk_device

//--- design/plk_host.sv
`timescale 1ns/1ns
`include "plk_defs.svh"

module plk_host (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst,
    plk_link_if.host                   link,
    input  wire plk_pkg::plk_byte_type i_pix_addr,
    input  wire logic                  i_blank_n,
    input  wire logic                  i_req,
    input  wire logic                  i_req_write,
    input  wire plk_pkg::plk_sel_type  i_req_sel,
    input  wire plk_pkg::plk_byte_type i_req_data,
    output logic                       o_req_ready,
    output logic                       o_rsp_valid,
    output plk_pkg::plk_byte_type      o_rsp_data
);
    import plk_pkg::*;

    plk_host_state_type state;
    plk_host_state_type next_state;
    logic               is_write;
    plk_sel_type        sel;
    plk_byte_type       data;
    logic [3:0]         count;
    logic [3:0]         next_count;
    plk_byte_type       pix_addr;
    logic               blank_n;

    // ----------------------------------------------------------------
    // Sequencing
    // ----------------------------------------------------------------
    // long gap after colour read or read address
    wire       long_gap = (!is_write && sel == `PLK_SEL_COLOR) ||
                          (is_write && sel == `PLK_SEL_RD_ADDR);
    wire [3:0] gap_cyc  = long_gap ? 4'(`PLK_GAP_LONG) : 4'(`PLK_GAP_SHORT);
    wire       count_done = (count == 4'h1);

    assign o_req_ready = (state == PLK_IDLE);

    // Next state
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            PLK_IDLE: begin
                if (i_req) begin
                    next_state = PLK_SETUP;
                    next_count = 4'(`PLK_SETUP_CYC);
                end
            end
            PLK_SETUP: begin
                next_count = count - 4'h1;
                if (count_done) begin
                    next_state = PLK_STROBE;
                    next_count = 4'(`PLK_STROBE_CYC);
                end
            end
            PLK_STROBE: begin
                next_count = count - 4'h1;
                if (count_done) begin
                    next_state = PLK_GAP;
                    next_count = gap_cyc;
                end
            end
            default: begin
                next_count = count - 4'h1;
                if (count_done) begin
                    next_state = PLK_IDLE;
                end
            end
        endcase
    end

    // State and request capture
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state    <= PLK_IDLE;
            count    <= 4'h0;
            is_write <= 1'b0;
            sel      <= 3'h0;
            data     <= 8'h00;
        end else begin
            state <= next_state;
            count <= next_count;
            if (state == PLK_IDLE && i_req) begin
                is_write <= i_req_write;
                sel      <= i_req_sel;
                data     <= i_req_data;
            end
        end
    end

    // Read data taken on last strobe cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rsp_valid <= 1'b0;
            o_rsp_data  <= 8'h00;
        end else begin
            o_rsp_valid <= 1'b0;
            if (state == PLK_STROBE && count_done && !is_write) begin
                o_rsp_valid <= 1'b1;
                o_rsp_data  <= link.data_bus;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pix_addr <= 8'h00;
            blank_n  <= 1'b0;
        end else begin
            pix_addr <= i_pix_addr;
            blank_n  <= i_blank_n;
        end
    end

    // Link drive
    assign link.pix_addr     = pix_addr;
    assign link.blank_n      = blank_n;
    assign link.sel          = sel;
    assign link.data_host    = data;
    assign link.data_host_oe = is_write && state != PLK_IDLE;
    assign link.wr_n         = !(state == PLK_STROBE && is_write);
    assign link.rd_n         = !(state == PLK_STROBE && !is_write);

endmodule : plk_host

//--- testbench/plk_link_monitor.sv
`timescale 1ns/1ns
`include "plk_defs.svh"

module plk_link_monitor (
    input wire logic                  i_clk_sys,
    input wire logic                  i_rst,
    input wire logic                  i_wr_n,
    input wire logic                  i_rd_n,
    input wire plk_pkg::plk_sel_type  i_sel,
    input wire plk_pkg::plk_byte_type i_data_host,
    input wire logic                  i_data_host_oe,
    input wire logic                  i_data_dev_oe
);
    import plk_pkg::*;

    // ------------------------------------------------------------
    // Host port pacing and strobe shape
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_wr_gap_min: assert property ($rose(i_wr_n) |-> (i_wr_n && i_rd_n) [*4])
        else $error("strobe too soon after write");
    a_rd_gap_min: assert property ($rose(i_rd_n) |-> (i_wr_n && i_rd_n) [*4])
        else $error("strobe too soon after read");
    a_color_rd_gap: assert property (
        $rose(i_rd_n) && $past(i_sel) == `PLK_SEL_COLOR |-> (i_wr_n && i_rd_n) [*8])
        else $error("strobe too soon after colour read");
    a_rdaddr_gap: assert property (
        $rose(i_wr_n) && $past(i_sel) == `PLK_SEL_RD_ADDR |-> i_rd_n [*8])
        else $error("read too soon after read address write");
    a_wr_width: assert property ($fell(i_wr_n) |-> !i_wr_n [*3] ##1 i_wr_n)
        else $error("write strobe width wrong");
    a_rd_width: assert property ($fell(i_rd_n) |-> !i_rd_n [*3] ##1 i_rd_n)
        else $error("read strobe width wrong");
    a_no_overlap: assert property (i_wr_n || i_rd_n)
        else $error("both strobes low");
    a_sel_hold: assert property (!i_wr_n || !i_rd_n |-> $stable(i_sel))
        else $error("select moved during strobe");
    a_wdata_hold: assert property (
        !i_wr_n |-> i_data_host_oe && $stable(i_data_host))
        else $error("write data not held");
    a_rd_drive: assert property (
        $fell(i_rd_n) |=> i_data_dev_oe [*2] ##1 !i_data_dev_oe)
        else $error("read data drive window wrong");
    a_dev_oe_rd: assert property (i_data_dev_oe |-> !i_rd_n && !$past(i_rd_n))
        else $error("device drives bus outside read");

    // Main traffic kinds seen
    c_color_wr: cover property ($rose(i_wr_n) && $past(i_sel) == `PLK_SEL_COLOR);
    c_color_rd: cover property ($rose(i_rd_n) && $past(i_sel) == `PLK_SEL_COLOR);
    c_rdaddr_wr: cover property ($rose(i_wr_n) && $past(i_sel) == `PLK_SEL_RD_ADDR);

endmodule : plk_link_monitor

//--- testbench/palette_lookup_host_pacing_tb_top.sv
`timescale 1ns/1ns
`include "plk_defs.svh"

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end

module palette_lookup_host_pacing_tb_top;
    import plk_pkg::*;

    typedef struct {
        plk_byte_type mask, addr;
        logic         bl;
        plk_byte_type r, g, b;
        logic         on;
    } plk_row_type;

    int           num_errors = 0;
    int           num_checks = 0;
    logic         clk_sys = 1'b0, rst = 1'b1, blank_n = 1'b1, req = 1'b0, req_write = 1'b0;
    plk_byte_type pix = 8'h00, req_data = 8'h00, rsp_data, red, green, blue, vword, mword;
    plk_sel_type  req_sel = 3'h0;
    logic         ready, rsp_valid, dac_on, wide;
    logic [2:0]   mode, vidx;
    plk_row_type  rows [6] = '{
        '{8'hff, 8'h05, 1'b1, 8'h11, 8'h22, 8'h33, 1'b1},
        '{8'hff, 8'h35, 1'b1, 8'h3f, 8'h00, 8'h15, 1'b1},
        '{8'hff, 8'hff, 1'b1, 8'h01, 8'h02, 8'h03, 1'b1},
        '{8'hff, 8'h35, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0},
        '{8'h0f, 8'h35, 1'b1, 8'h11, 8'h22, 8'h33, 1'b1},
        '{8'h35, 8'hff, 1'b1, 8'h3f, 8'h00, 8'h15, 1'b1}};

    // Clock
    always #10 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Both ends joined across the link
    // ------------------------------------------------------------
    plk_link_if plk_link_if_inst ();

    plk_device plk_device_inst (.i_clk_sys(clk_sys), .i_rst(rst), .link(plk_link_if_inst.dev),
        .o_red(red), .o_green(green), .o_blue(blue), .o_dac_on(dac_on), .o_dac_wide(wide),
        .o_video_mode(mode), .o_video_clock_index(vidx), .o_video_clock_out_word(vword),
        .o_memory_clock_out_word(mword));

    plk_host plk_host_inst (.i_clk_sys(clk_sys), .i_rst(rst), .link(plk_link_if_inst.host),
        .i_pix_addr(pix), .i_blank_n(blank_n), .i_req(req), .i_req_write(req_write),
        .i_req_sel(req_sel), .i_req_data(req_data), .o_req_ready(ready),
        .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data));

    plk_link_monitor plk_link_monitor_inst (.i_clk_sys(clk_sys), .i_rst(rst),
        .i_wr_n(plk_link_if_inst.wr_n), .i_rd_n(plk_link_if_inst.rd_n),
        .i_sel(plk_link_if_inst.sel), .i_data_host(plk_link_if_inst.data_host),
        .i_data_host_oe(plk_link_if_inst.data_host_oe),
        .i_data_dev_oe(plk_link_if_inst.data_dev_oe));

    // ------------------------------------------------------------
    // Tasks, all entered at a falling edge
    // ------------------------------------------------------------
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        if (ready !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED t=%0t host never ready", $time);
        end
    endtask : wait_ready

    task automatic send(input logic wr, input plk_sel_type s, input plk_byte_type d);
        wait_ready();
        req = 1'b1;
        req_write = wr;
        req_sel = s;
        req_data = d;
        @(negedge clk_sys);
        req = 1'b0;
    endtask : send

    task automatic fetch(input plk_sel_type s, input plk_byte_type exp);
        int n;
        send(1'b0, s, 8'h00);
        for (n = 0; n < 20 && rsp_valid !== 1'b1; n++) begin
            @(negedge clk_sys);
        end
        `CHK(rsp_valid, 1'b1)
        `CHK(rsp_data, exp)
    endtask : fetch

    task automatic put(input plk_byte_type a, r, g, b);
        send(1'b1, `PLK_SEL_WR_ADDR, a);
        send(1'b1, `PLK_SEL_COLOR, r);
        send(1'b1, `PLK_SEL_COLOR, g);
        send(1'b1, `PLK_SEL_COLOR, b);
    endtask : put

    task automatic show(input plk_byte_type a, input logic bl);
        wait_ready();
        @(negedge clk_sys);
        pix = a;
        blank_n = bl;
        repeat (6) @(negedge clk_sys);
    endtask : show

    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // Watchdog
    initial begin
        #(20 * 5000);
        num_errors++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK(mode, 3'h0)
        `CHK(vword, `PLK_PLL_DEFAULT_BASE)
        `CHK(mword, `PLK_PLL_DEFAULT_BASE + 8'h08)
        put(8'h05, 8'h11, 8'h22, 8'h33);
        put(8'h35, 8'h3f, 8'h00, 8'h15);
        put(8'hff, 8'h01, 8'h02, 8'h03);
        foreach (rows[i]) begin
            send(1'b1, `PLK_SEL_MASK, rows[i].mask);
            show(rows[i].addr, rows[i].bl);
            `CHK(red, rows[i].r)
            `CHK(green, rows[i].g)
            `CHK(blue, rows[i].b)
            `CHK(dac_on, rows[i].on)
        end
        // Blank pulse on one pixel stays aligned with it
        show(8'h05, 1'b1);
        pix = 8'hff;
        blank_n = 1'b0;
        @(negedge clk_sys);
        blank_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK(red, 8'h11)
        @(negedge clk_sys);
        `CHK(red, 8'h00)
        `CHK(dac_on, 1'b0)
        @(negedge clk_sys);
        `CHK(red, 8'h3f)
        `CHK(dac_on, 1'b1)
        // Read back through the read address
        send(1'b1, `PLK_SEL_RD_ADDR, 8'h35);
        fetch(`PLK_SEL_COLOR, 8'h3f);
        fetch(`PLK_SEL_COLOR, 8'h00);
        fetch(`PLK_SEL_COLOR, 8'h15);
        fetch(`PLK_SEL_RD_ADDR, 8'h36);
        fetch(`PLK_SEL_MASK, 8'h35);
        // Clock words: programmable, fixed refused, memory word
        send(1'b1, `PLK_SEL_PLL_CTRL, 8'h02);
        send(1'b1, `PLK_SEL_PLL_INDEX, 8'h02);
        send(1'b1, `PLK_SEL_PLL_DATA, 8'h5a);
        wait_ready();
        `CHK(vidx, 3'h2)
        `CHK(vword, 8'h5a)
        send(1'b1, `PLK_SEL_PLL_INDEX, 8'h00);
        send(1'b1, `PLK_SEL_PLL_DATA, 8'h77);
        send(1'b1, `PLK_SEL_PLL_CTRL, 8'h00);
        send(1'b1, `PLK_SEL_PLL_INDEX, 8'h08);
        send(1'b1, `PLK_SEL_PLL_DATA, 8'h2d);
        wait_ready();
        `CHK(vword, `PLK_PLL_DEFAULT_BASE)
        `CHK(mword, 8'h2d)
        fetch(`PLK_SEL_PLL_DATA, 8'h2d);
        // Wide converters and mode bits
        send(1'b1, `PLK_SEL_COMMAND, 8'he2);
        send(1'b1, `PLK_SEL_MASK, 8'h0f);
        show(8'h35, 1'b1);
        `CHK(mode, 3'h7)
        `CHK(wide, 1'b1)
        `CHK(red, 8'h44)
        `CHK(blue, 8'hcc)
        fetch(`PLK_SEL_COMMAND, 8'he2);
        // Reset in mid-run restores mask and mode, keeps palette
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        `CHK(mode, 3'h0)
        `CHK(wide, 1'b0)
        `CHK(red, 8'h3f)
        stop_test();
    end

endmodule : palette_lookup_host_pacing_tb_top
